// ==== core/gecr_regs.sv ====
// general control and general-purpose event register bank behind an apb slave
// assumes pins on MULTI_TERMINAL_IN are asynchronous; all else is on CLK
//
// What this block does
// - bit 10 selects external supply switch type
// - bit 3 set turns 1394 function off
// - bits 1-0 pick arbitration priority or round robin
// - reserved control bits always read zero
// - power state write change sets power flag
// - 12 V programming change sets its flag
// - input level change sets flag if input
// - status flags read, hardware set, software clear
// - status and enable bit 5 read zero
// - enabled pending flag asserts event output
// - input register mirrors inputs; upper bits zero
// - select 0000 input, 1110 drives event out
`timescale 1ns/1ps
`default_nettype none
module gecr_regs #(
  parameter int ADDR_W = 12
) (
  // clock, enable and reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // multifunction terminals, slots 4..0 are terminals 5,4,2,1,0
  input wire logic [4:0] MULTI_TERMINAL_IN,
  output logic [4:0] MULTI_TERMINAL_OUT,
  output logic [4:0] MULTI_TERMINAL_OE,
  // event output
  output logic EVENT_SIGNAL_OUT_N,
  // controls to the rest of the device
  output logic SUPPLY_SWITCH_SELECT,
  output logic HOST1394_FUNCTION_OFF,
  output logic ARB_PRIO_1394,
  output logic ARB_PRIO_CARDBUS,
  output logic ARB_ROUND_ROBIN,
  output logic [7:0] SOCKET_POWER
);

  // true when the bus address selects the register at this index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {{(ADDR_W-10){1'b0}}, idx, 2'b00});
  endfunction

  // true when a programming supply field asks for 12 V
  function automatic logic is_12v(input logic [1:0] vpp);
    is_12v = (vpp == gecr_pkg::VPP_12V);
  endfunction

  // bit position of the select field for an input slot
  function automatic int sel_lsb(input int slot);
    case (slot)
      0: sel_lsb = gecr_pkg::TSEL_LSB0;
      1: sel_lsb = gecr_pkg::TSEL_LSB1;
      2: sel_lsb = gecr_pkg::TSEL_LSB2;
      3: sel_lsb = gecr_pkg::TSEL_LSB3;
      default: sel_lsb = gecr_pkg::TSEL_LSB4;
    endcase
  endfunction

  // decodes the two arbitration bits into a policy
  function automatic gecr_pkg::gecr_arb_type arb_decode(input logic [1:0] code);
    case (code)
      2'b00: arb_decode = gecr_pkg::ARB_FIX_1394;
      2'b01: arb_decode = gecr_pkg::ARB_FIX_CARDBUS;
      default: arb_decode = gecr_pkg::ARB_FAIR;
    endcase
  endfunction

  // bus phase tracking
  gecr_pkg::gecr_bus_type bus_state_r;
  gecr_pkg::gecr_bus_type bus_state_nxt;
  // setup cycle seen this edge
  logic setup_seen;
  // write committed this edge
  logic wr_go;
  // address matches any register
  logic addr_mapped;
  // read data for the current address
  logic [31:0] rd_data;

  // control register fields
  logic supply_sel_r;
  logic fn_off_r;
  logic [1:0] arb_r;
  // event status and enable, bit 5 held zero
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] enable_r;
  // set and clear terms for status
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  // terminal select fields
  logic [3:0] sel_r [gecr_pkg::NUM_INPUTS];
  // socket power request
  logic [7:0] power_r;
  // synchronised and previous input levels
  logic [4:0] lvl_sync;
  logic [4:0] lvl_prev_r;
  // event pending and enabled
  logic event_pending;
  // synchroniser fill marker; a pin held high through reset
  // must not look like a level change once reset lifts
  logic [2:0] warm_r;

  // pin levels cross into the clock domain here
  gecr_sync #(
    .WIDTH(gecr_pkg::NUM_INPUTS)
  ) u_sync (
    .clk(CLK),
    .ce(CE),
    .rst_b(RST_B),
    .d(MULTI_TERMINAL_IN),
    .q(lvl_sync)
  );

  // bus qualifiers
  assign setup_seen = PSEL && !PENABLE;
  assign wr_go = PSEL && PENABLE && PWRITE && (bus_state_r == gecr_pkg::BUS_ANSWER);

  // address decode; reserved map holes answer with an error
  always_comb begin
    addr_mapped = hit(PADDR, gecr_pkg::IDX_GENERAL_CONTROL) ||
                  hit(PADDR, gecr_pkg::IDX_EVENT_STATUS) ||
                  hit(PADDR, gecr_pkg::IDX_EVENT_ENABLE) ||
                  hit(PADDR, gecr_pkg::IDX_INPUT_LEVELS) ||
                  hit(PADDR, gecr_pkg::IDX_TERMINAL_SELECT) ||
                  hit(PADDR, gecr_pkg::IDX_SOCKET_POWER);
  end

  // read data mux
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(PADDR, gecr_pkg::IDX_GENERAL_CONTROL)) begin
      rd_data[gecr_pkg::GC_SUPPLY_SWITCH_BIT] = supply_sel_r;
      rd_data[gecr_pkg::GC_1394_OFF_BIT] = fn_off_r;
      rd_data[gecr_pkg::GC_ARB_LSB +: 2] = arb_r;
    end else if (hit(PADDR, gecr_pkg::IDX_EVENT_STATUS)) begin
      rd_data[7:0] = status_r & gecr_pkg::EV_VALID_MASK;
    end else if (hit(PADDR, gecr_pkg::IDX_EVENT_ENABLE)) begin
      rd_data[7:0] = enable_r & gecr_pkg::EV_VALID_MASK;
    end else if (hit(PADDR, gecr_pkg::IDX_INPUT_LEVELS)) begin
      rd_data[4:0] = lvl_sync;
    end else if (hit(PADDR, gecr_pkg::IDX_TERMINAL_SELECT)) begin
      for (int i = 0; i < gecr_pkg::NUM_INPUTS; i++) begin
        rd_data[sel_lsb(i) +: 4] = sel_r[i];
      end
    end else if (hit(PADDR, gecr_pkg::IDX_SOCKET_POWER)) begin
      rd_data[7:0] = power_r;
    end
  end

  // answer phase: one access cycle, no wait states
  always_comb begin
    case (bus_state_r)
      gecr_pkg::BUS_IDLE: begin
        bus_state_nxt = setup_seen ? gecr_pkg::BUS_ANSWER : gecr_pkg::BUS_IDLE;
      end
      gecr_pkg::BUS_ANSWER: begin
        // a new setup may follow at once
        bus_state_nxt = gecr_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_nxt = gecr_pkg::BUS_IDLE;
      end
    endcase
  end

  // bus answer registers; data captured in setup so outputs come from flops
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      bus_state_r <= gecr_pkg::BUS_IDLE;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (CE) begin
      bus_state_r <= bus_state_nxt;
      PREADY <= (bus_state_nxt == gecr_pkg::BUS_ANSWER);
      if (setup_seen) begin
        // error on holes; read data zero there
        PSLVERR <= !addr_mapped;
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_data;
      end else begin
        PSLVERR <= 1'b0;
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // general control register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      supply_sel_r <= gecr_pkg::GC_SUPPLY_SWITCH_RESET;
      fn_off_r <= gecr_pkg::GC_1394_OFF_RESET;
      arb_r <= gecr_pkg::GC_ARB_RESET;
    end else if (CE && wr_go && hit(PADDR, gecr_pkg::IDX_GENERAL_CONTROL)) begin
      supply_sel_r <= PWDATA[gecr_pkg::GC_SUPPLY_SWITCH_BIT];
      fn_off_r <= PWDATA[gecr_pkg::GC_1394_OFF_BIT];
      arb_r <= PWDATA[gecr_pkg::GC_ARB_LSB +: 2];
    end
  end

  // control outputs, one cycle after the write commits
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      SUPPLY_SWITCH_SELECT <= gecr_pkg::GC_SUPPLY_SWITCH_RESET;
      HOST1394_FUNCTION_OFF <= gecr_pkg::GC_1394_OFF_RESET;
      ARB_PRIO_1394 <= 1'b1;
      ARB_PRIO_CARDBUS <= 1'b0;
      ARB_ROUND_ROBIN <= 1'b0;
      SOCKET_POWER <= gecr_pkg::SOCKET_POWER_RESET;
    end else if (CE) begin
      SUPPLY_SWITCH_SELECT <= supply_sel_r;
      HOST1394_FUNCTION_OFF <= fn_off_r;
      // both high codes mean fair round robin
      ARB_PRIO_1394 <= (arb_decode(arb_r) == gecr_pkg::ARB_FIX_1394);
      ARB_PRIO_CARDBUS <= (arb_decode(arb_r) == gecr_pkg::ARB_FIX_CARDBUS);
      ARB_ROUND_ROBIN <= (arb_decode(arb_r) == gecr_pkg::ARB_FAIR);
      SOCKET_POWER <= power_r;
    end
  end

  // socket power request register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      power_r <= gecr_pkg::SOCKET_POWER_RESET;
    end else if (CE && wr_go && hit(PADDR, gecr_pkg::IDX_SOCKET_POWER)) begin
      power_r <= PWDATA[7:0];
    end
  end

  // terminal select register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < gecr_pkg::NUM_INPUTS; i++) begin
        sel_r[i] <= gecr_pkg::TSEL_RESET;
      end
    end else if (CE && wr_go && hit(PADDR, gecr_pkg::IDX_TERMINAL_SELECT)) begin
      for (int i = 0; i < gecr_pkg::NUM_INPUTS; i++) begin
        sel_r[i] <= PWDATA[sel_lsb(i) +: 4];
      end
    end
  end

  // event enable register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      enable_r <= gecr_pkg::EV_ENABLE_RESET;
    end else if (CE && wr_go && hit(PADDR, gecr_pkg::IDX_EVENT_ENABLE)) begin
      enable_r <= PWDATA[7:0] & gecr_pkg::EV_VALID_MASK;
    end
  end

  // pipe fill after reset; a pin change inside these edges is not flagged
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      warm_r <= 3'b000;
    end else if (CE) begin
      warm_r <= {warm_r[1:0], 1'b1};
    end
  end

  // previous level, tracked always so a newly selected input starts clean
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      lvl_prev_r <= gecr_pkg::INPUT_LEVEL_RESET;
    end else if (CE) begin
      lvl_prev_r <= lvl_sync;
    end
  end

  // hardware set terms
  always_comb begin
    ev_set = 8'h00;
    // level change on a terminal used as input
    for (int i = 0; i < gecr_pkg::NUM_INPUTS; i++) begin
      // only select 0000 makes it an input
      ev_set[i] = warm_r[2] && (sel_r[i] == gecr_pkg::SEL_GP_INPUT) &&
                  (lvl_sync[i] != lvl_prev_r[i]);
    end
    if (wr_go && hit(PADDR, gecr_pkg::IDX_SOCKET_POWER)) begin
      // any change of either socket's supplies
      ev_set[gecr_pkg::EV_POWER_BIT] = (PWDATA[7:0] != power_r);
      // either socket moves to or from 12 V
      ev_set[gecr_pkg::EV_VPP12_BIT] =
        (is_12v(PWDATA[gecr_pkg::VPP_A_LSB +: 2]) != is_12v(power_r[gecr_pkg::VPP_A_LSB +: 2])) ||
        (is_12v(PWDATA[gecr_pkg::VPP_B_LSB +: 2]) != is_12v(power_r[gecr_pkg::VPP_B_LSB +: 2]));
    end
  end

  // software clear terms
  always_comb begin
    ev_clr = 8'h00;
    // ones written clear, zeros leave flags alone
    if (wr_go && hit(PADDR, gecr_pkg::IDX_EVENT_STATUS)) begin
      ev_clr = PWDATA[7:0];
    end
  end

  // flags set by hardware, cleared by software only
  // set after clear so a same-cycle event survives
  assign status_nxt = ((status_r & ~ev_clr) | ev_set) & gecr_pkg::EV_VALID_MASK;

  // event status register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      status_r <= gecr_pkg::EV_STATUS_RESET;
    end else if (CE) begin
      status_r <= status_nxt;
    end
  end

  // any enabled pending flag raises the event
  assign event_pending = |(status_r & enable_r);

  // event output and terminal drive; the pin follows one cycle after the flag
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      EVENT_SIGNAL_OUT_N <= 1'b1;
      MULTI_TERMINAL_OUT <= 5'h1f;
      MULTI_TERMINAL_OE <= 5'h00;
    end else if (CE) begin
      // low while anything enabled stays pending
      EVENT_SIGNAL_OUT_N <= !event_pending;
      for (int i = 0; i < gecr_pkg::NUM_INPUTS; i++) begin
        // select 1110 routes the event to the terminal
        MULTI_TERMINAL_OE[i] <= (sel_r[i] == gecr_pkg::SEL_EVENT_OUT);
        MULTI_TERMINAL_OUT[i] <= !event_pending;
      end
    end
  end

endmodule
`default_nettype wire

// ==== core/gecr_pkg.sv ====
// constants, field positions and types of the general control and event register bank
// assumes a 32-bit apb slave; each register index maps to byte address index*4
package gecr_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_GENERAL_CONTROL = 8'h86;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h88;
  localparam logic [7:0] IDX_EVENT_ENABLE = 8'h89;
  localparam logic [7:0] IDX_INPUT_LEVELS = 8'h8a;
  localparam logic [7:0] IDX_TERMINAL_SELECT = 8'h8c;
  localparam logic [7:0] IDX_SOCKET_POWER = 8'h90;

  // general control fields
  localparam int GC_SUPPLY_SWITCH_BIT = 10;
  localparam int GC_1394_OFF_BIT = 3;
  localparam int GC_ARB_LSB = 0;
  localparam logic GC_SUPPLY_SWITCH_RESET = 1'h0;
  localparam logic GC_1394_OFF_RESET = 1'h0;
  localparam logic [1:0] GC_ARB_RESET = 2'h0;

  // event status / enable fields
  localparam int EV_POWER_BIT = 7;
  localparam int EV_VPP12_BIT = 6;
  localparam logic [7:0] EV_VALID_MASK = 8'hdf;
  localparam logic [7:0] EV_STATUS_RESET = 8'h00;
  localparam logic [7:0] EV_ENABLE_RESET = 8'h00;

  // general-purpose inputs
  localparam int NUM_INPUTS = 5;
  localparam logic [4:0] INPUT_LEVEL_RESET = 5'h00;

  // terminal select fields: terminals 0,1,2,4,5 map to input slots 0..4
  localparam int TSEL_LSB0 = 0;
  localparam int TSEL_LSB1 = 4;
  localparam int TSEL_LSB2 = 8;
  localparam int TSEL_LSB3 = 16;
  localparam int TSEL_LSB4 = 20;
  localparam logic [3:0] TSEL_RESET = 4'h0;
  localparam logic [3:0] SEL_GP_INPUT = 4'h0;
  localparam logic [3:0] SEL_EVENT_OUT = 4'he;

  // socket power request fields
  localparam int VCC_A_LSB = 0;
  localparam int VPP_A_LSB = 2;
  localparam int VCC_B_LSB = 4;
  localparam int VPP_B_LSB = 6;
  localparam logic [1:0] VPP_12V = 2'h2;
  localparam logic [7:0] SOCKET_POWER_RESET = 8'h00;

  // bus answer phase
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } gecr_bus_type;

  // decoded arbitration policy
  typedef enum logic [1:0] {
    ARB_FIX_1394 = 2'b00,
    ARB_FIX_CARDBUS = 2'b01,
    ARB_FAIR = 2'b10
  } gecr_arb_type;

endpackage

// ==== core/gecr_sync.sv ====
// two-flop synchroniser for a group of asynchronous pin levels
// assumes one clock, a clock enable that freezes it, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module gecr_sync #(
  parameter int WIDTH = 5
) (
  // clock and control
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_b,
  // asynchronous levels in
  input wire logic [WIDTH-1:0] d,
  // synchronised levels out
  output logic [WIDTH-1:0] q
);

  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // two stages give metastability time to settle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ==== verification/gecr_regs_chk.sv ====
// port assertions for the general control and event register bank
// assumes bind from the bench top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module gecr_chk #(
  parameter int ADDR_W = 12
) (
  // clock, enable, reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST_B,
  // apb slave side
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // terminals and event
  input wire logic [4:0] MULTI_TERMINAL_OUT,
  input wire logic [4:0] MULTI_TERMINAL_OE,
  input wire logic EVENT_SIGNAL_OUT_N,
  // controls out
  input wire logic SUPPLY_SWITCH_SELECT,
  input wire logic HOST1394_FUNCTION_OFF,
  input wire logic ARB_PRIO_1394,
  input wire logic ARB_PRIO_CARDBUS,
  input wire logic ARB_ROUND_ROBIN
);
  // byte addresses, four times the index
  localparam logic [ADDR_W-1:0] A_GC = ADDR_W'(12'h218);
  localparam logic [ADDR_W-1:0] A_ST = ADDR_W'(12'h220);
  localparam logic [ADDR_W-1:0] A_EN = ADDR_W'(12'h224);
  localparam logic [ADDR_W-1:0] A_IN = ADDR_W'(12'h228);
  localparam logic [ADDR_W-1:0] A_TS = ADDR_W'(12'h230);

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // a completed write, at its commit edge
  sequence wr_done;
    PSEL && PENABLE && PWRITE && PREADY && CE;
  endsequence
  // write to the control register
  sequence gc_wr;
    wr_done ##0 (PADDR == A_GC);
  endsequence
  // read answer from one address
  sequence rd_at(logic [ADDR_W-1:0] a);
    PREADY && !PWRITE && PADDR == a;
  endsequence

  arb_onehot_a: assert property ($onehot({ARB_PRIO_1394, ARB_PRIO_CARDBUS, ARB_ROUND_ROBIN}))
    else $error("arbitration decode not one-hot");
  arb_write_a: assert property (gc_wr |=> ##1 ARB_ROUND_ROBIN == $past(PWDATA[1], 2)
    && ARB_PRIO_CARDBUS == ($past(PWDATA[1:0], 2) == 2'h1))
    else $error("arbitration policy wrong");
  switch_write_a: assert property (gc_wr |=> ##1 SUPPLY_SWITCH_SELECT == $past(PWDATA[10], 2))
    else $error("switch select wrong");
  fn_off_write_a: assert property (gc_wr |=> ##1 HOST1394_FUNCTION_OFF == $past(PWDATA[3], 2))
    else $error("function off wrong");
  gc_reserved_a: assert property (rd_at(A_GC) |-> (PRDATA & ~32'h0000040b) == 32'h0)
    else $error("control reserved bits not zero");
  bit5_zero_a: assert property (PREADY && !PWRITE && (PADDR == A_ST || PADDR == A_EN)
    |-> !PRDATA[5]) else $error("bit 5 not zero");
  in_upper_a: assert property (rd_at(A_IN) |-> PRDATA[31:5] == 27'h0)
    else $error("input upper bits not zero");
  term_mirror_a: assert property (MULTI_TERMINAL_OUT == {5{EVENT_SIGNAL_OUT_N}})
    else $error("terminal event level differs");
  event_release_a: assert property ($rose(EVENT_SIGNAL_OUT_N) |-> $past(PSEL && PENABLE
    && PWRITE && PREADY, 2)) else $error("event released without a write");
  oe_write_a: assert property (wr_done ##0 (PADDR == A_TS) |=> ##1 MULTI_TERMINAL_OE[0]
    == ($past(PWDATA[3:0], 2) == 4'he)) else $error("terminal drive enable wrong");
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the register bank, apb master in the bench
// assumes CE held high; pins driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // row: address, write data, read-back, {switch, off, p1394, pcb, rr}
  typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] ex; logic [4:0] ctl;} gecr_row_type;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [4:0] pins = 5'h00;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, EVN, SUP, OFF, P13, PCB, RR, err;
  logic [4:0] TOUT, OE;
  logic [7:0] SPWR;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  gecr_row_type rows [10] = '{
    '{12'h218, 32'hffffffff, 32'h0000040b, 5'h19}, '{12'h218, 32'h00000402, 32'h00000402, 5'h11},
    '{12'h218, 32'h00000001, 32'h00000001, 5'h02}, '{12'h218, 32'h00000002, 32'h00000002, 5'h01},
    '{12'h218, 32'h00000000, 32'h00000000, 5'h04}, '{12'h218, 32'h00000008, 32'h00000008, 5'h0c},
    '{12'h224, 32'hffffffff, 32'h000000df, 5'h0}, '{12'h224, 32'h00000020, 32'h00000000, 5'h0},
    '{12'h228, 32'hffffffff, 32'h00000000, 5'h0}, '{12'h220, 32'hffffffff, 32'h00000000, 5'h0}};

  gecr_regs dut_u (.CLK(CLK), .CE(1'b1), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MULTI_TERMINAL_IN(pins), .MULTI_TERMINAL_OUT(TOUT),
    .MULTI_TERMINAL_OE(OE), .EVENT_SIGNAL_OUT_N(EVN), .SUPPLY_SWITCH_SELECT(SUP),
    .HOST1394_FUNCTION_OFF(OFF), .ARB_PRIO_1394(P13), .ARB_PRIO_CARDBUS(PCB),
    .ARB_ROUND_ROBIN(RR), .SOCKET_POWER(SPWR));

  // 250 MHz clock
  always #2 CLK = ~CLK;

  // hang guard, well above the expected run
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; data taken at the rising edge that sees pready high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // pready seen high ends this wait; if it never rises only the hang guard does
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic pin_set(input logic [4:0] v);
    @(posedge CLK);
    pins <= v;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    // table: write, read back, control outputs
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].ex);
      if (rows[i].a == 12'h218) check({27'h0, SUP, OFF, P13, PCB, RR}, {27'h0, rows[i].ctl});
    end
    $display("done table");
    // socket power changes raise flags and event
    apb(1'b1, 12'h224, 32'hc0);
    apb(1'b1, 12'h240, 32'h08);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'hc0);
    check({31'h0, EVN}, 32'h0);
    apb(1'b1, 12'h220, 32'h40);
    apb(1'b1, 12'h240, 32'h08);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'h80);
    apb(1'b1, 12'h240, 32'h01);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'hc0);
    check({24'h0, SPWR}, 32'h01);
    apb(1'b1, 12'h220, 32'hff);
    apb(1'b0, 12'h220, 32'h0);
    check({rd[30:0], EVN}, 32'h1);
    $display("done power");
    // pin changes, masking, terminal routing
    apb(1'b1, 12'h224, 32'h1f);
    pin_set(5'h15);
    repeat (5) @(posedge CLK);
    apb(1'b0, 12'h228, 32'h0);
    check(rd, 32'h15);
    apb(1'b0, 12'h220, 32'h0);
    check({rd[30:0], EVN}, 32'h2a);
    check({27'h0, TOUT}, 32'h0);
    apb(1'b1, 12'h224, 32'h0);
    apb(1'b0, 12'h224, 32'h0);
    check({rd[30:0], EVN}, 32'h1);
    apb(1'b1, 12'h220, 32'hff);
    apb(1'b1, 12'h230, 32'he);
    // drive enable follows the select one edge after the commit
    repeat (2) @(posedge CLK);
    check({27'h0, OE}, 32'h1);
    pin_set(5'h14);
    repeat (5) @(posedge CLK);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h230, 32'h0);
    // set at the clear's own edge wins
    pin_set(5'h04);
    apb(1'b1, 12'h220, 32'h10);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'h10);
    apb(1'b1, 12'h3fc, 32'hff);
    check({31'h0, err}, 32'h1);
    $display("done pins");
    // mid-run reset
    @(posedge CLK);
    RST_B <= 1'b0;
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    apb(1'b0, 12'h218, 32'h0);
    check({rd[28:0], EVN, P13, SUP}, 32'h6);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'h0);
    $display("done reset");
    report_and_stop();
  end
endmodule

bind gecr_regs gecr_chk #(.ADDR_W(ADDR_W)) chk_u (.CLK, .CE, .RST_B, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MULTI_TERMINAL_OUT, .MULTI_TERMINAL_OE,
  .EVENT_SIGNAL_OUT_N, .SUPPLY_SWITCH_SELECT, .HOST1394_FUNCTION_OFF, .ARB_PRIO_1394,
  .ARB_PRIO_CARDBUS, .ARB_ROUND_ROBIN);
`default_nettype wire
